// file: hdl/asb_serial_core.sv
`timescale 1ns/1ps
module asb_serial_core
  import asb_pkg::*;
(
  input wire logic clk_sys, // System clock, 125 MHz
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic [2:0] speed_select_field, // Power-of-two divider code
  input wire logic prescale_select, // Prescale 10 or 30
  input wire logic oversample_select, // Clock-mode select low bit
  input wire logic unity_clock_select, // Clock-mode select high bit
  input wire logic generator_mode_select, // Use time-constant counter
  input wire logic [15:0] time_constant, // Generator reload value
  input wire logic ext_serial_clock_pin, // External serial clock
  output logic rx_bit_tick, // Receiver clock strobe
  output logic tx_bit_tick, // Transmitter clock strobe
  input wire logic shift_char_valid, // Character done in shift reg
  input wire logic [7:0] shift_char_data, // Completed character
  input wire logic shift_parity_err, // Character parity bad
  input wire logic shift_framing_err, // Character stop bit bad
  input wire logic rx_read_ready, // Reader takes head char
  output logic [7:0] rx_read_data, // Head character
  output logic rx_data_full_flag, // Character available
  output logic parity_error_flag, // Sticky parity error
  output logic framing_error_flag, // Sticky framing error
  output logic overrun_flag, // Sticky overrun
  input wire logic error_clear, // Clear the three error flags
  input wire logic inhibit_write, // Load the inhibit bit
  input wire logic inhibit_wdata, // New inhibit value
  output logic dfull_irq_inhibit, // Data-full interrupt inhibit
  input wire logic rx_interrupt_enable, // Receive interrupt enable
  input wire logic rx_dma_enable, // Receive DMA enable
  input wire logic carrier_detect_input, // Carrier detect event level
  output logic rx_interrupt, // Receive interrupt request
  output logic rx_dma_request // Receive DMA request
);

  ////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic [5:0] mode_limit(input asb_clock_mode_type m);
    logic [5:0] lim;
    lim = MODE_LIMIT_X16;
    unique case (m)
      ASB_MODE_X16: lim = MODE_LIMIT_X16;
      ASB_MODE_X64: lim = MODE_LIMIT_X64;
      ASB_MODE_X1: lim = MODE_LIMIT_X1;
      ASB_MODE_RSVD: lim = MODE_LIMIT_X16;
    endcase
    return lim;
  endfunction

  function automatic logic [10:0] classic_limit(input logic ps, input logic [2:0] ss);
    logic [10:0] base;
    base = ps ? (CLASSIC_BASE_DIV + PRESCALE_EXTRA_DIV) : CLASSIC_BASE_DIV;
    return (base << ss) - 11'h001;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Source selection

  asb_clock_mode_type clock_mode;
  logic ext_mode;
  logic ext_prev_q;
  logic ext_rise;
  logic src_tick;

  assign clock_mode = asb_clock_mode_type'({unity_clock_select, oversample_select});
  assign ext_mode = (speed_select_field == SPEED_EXT_CLOCK);
  assign ext_rise = ext_serial_clock_pin & ~ext_prev_q;

  // No reset: a pin already high at release must not count as an edge
  always_ff @(posedge clk_sys) begin
    ext_prev_q <= ext_serial_clock_pin;
  end

  ////////////////////////////////////////////////////////////////////
  // Time-constant generator

  logic [16:0] gen_cnt_q;
  logic gen_phase_q;
  logic gen_expire;

  // Half period is TC+2 clocks; a tick every second half
  assign gen_expire = (gen_cnt_q == 17'h00000);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      gen_cnt_q <= 17'h00000;
      gen_phase_q <= 1'b0;
    end else if (gen_expire) begin
      gen_cnt_q <= {1'b0, time_constant} + TC_HALF_OFFSET - 17'h00001;
      gen_phase_q <= ~gen_phase_q;
    end else begin
      gen_cnt_q <= gen_cnt_q - 17'h00001;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Classic prescaler

  logic [10:0] cls_cnt_q;
  logic cls_expire;

  assign cls_expire = (cls_cnt_q == 11'h000);

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cls_cnt_q <= 11'h000;
    end else if (cls_expire) begin
      cls_cnt_q <= classic_limit(prescale_select, speed_select_field);
    end else begin
      cls_cnt_q <= cls_cnt_q - 11'h001;
    end
  end

  always_comb begin
    if (ext_mode) begin
      src_tick = ext_rise;
    end else if (generator_mode_select) begin
      src_tick = gen_expire & gen_phase_q;
    end else begin
      src_tick = cls_expire;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Clock-mode dividers, one for receiver and one for transmitter

  logic [1:0] mode_tick;
  logic [1:0] mode_tick_q;

  // Reserved mode code stops both dividers rather than guess a factor
  generate
    for (genvar i = 0; i < 2; i++) begin : g_mode_div
      logic [5:0] div_cnt_q;
      logic div_hit;
      // A count left over from a larger factor ends at once
      assign div_hit = (div_cnt_q == 6'h00) || (div_cnt_q > mode_limit(clock_mode));
      assign mode_tick[i] = src_tick & (clock_mode != ASB_MODE_RSVD) & div_hit;
      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          div_cnt_q <= 6'h00;
        end else if (src_tick && clock_mode != ASB_MODE_RSVD) begin
          if (div_hit) begin
            div_cnt_q <= mode_limit(clock_mode);
          end else begin
            div_cnt_q <= div_cnt_q - 6'h01;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      mode_tick_q <= 2'h0;
    end else begin
      mode_tick_q <= mode_tick;
    end
  end

  assign rx_bit_tick = mode_tick_q[0];
  assign tx_bit_tick = mode_tick_q[1];

  ////////////////////////////////////////////////////////////////////
  // Receive FIFO

  logic [RX_ENTRY_WIDTH-1:0] fifo_mem_q [RX_FIFO_DEPTH];
  logic [RX_PTR_WIDTH-1:0] fifo_wr_q;
  logic [RX_PTR_WIDTH-1:0] fifo_rd_q;
  logic [2:0] fifo_cnt_q;
  logic fifo_full;
  logic fifo_push;
  logic fifo_pop;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [RX_ENTRY_WIDTH-1:0] buf_out_data;
  logic char_taken;

  assign fifo_full = (fifo_cnt_q == RX_FIFO_FULL_CNT);
  assign fifo_push = shift_char_valid & ~fifo_full;
  assign fifo_pop = (fifo_cnt_q != 3'h0) & buf_in_ready;

  always_ff @(posedge clk_sys) begin
    if (fifo_push) begin
      fifo_mem_q[fifo_wr_q] <= {shift_parity_err, shift_framing_err, shift_char_data};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      fifo_wr_q <= '0;
      fifo_rd_q <= '0;
      fifo_cnt_q <= 3'h0;
    end else begin
      if (fifo_push) begin
        fifo_wr_q <= fifo_wr_q + 2'h1;
      end
      if (fifo_pop) begin
        fifo_rd_q <= fifo_rd_q + 2'h1;
      end
      fifo_cnt_q <= fifo_cnt_q + {2'h0, fifo_push} - {2'h0, fifo_pop};
    end
  end

  // Buffer keeps the head word steady while the reader stalls
  asb_pair_buffer #(
    .WIDTH(RX_ENTRY_WIDTH)
  ) u_out_buf (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .in_valid(fifo_cnt_q != 3'h0),
    .in_ready(buf_in_ready),
    .in_data(fifo_mem_q[fifo_rd_q]),
    .out_valid(buf_out_valid),
    .out_ready(rx_read_ready),
    .out_data(buf_out_data)
  );

  // Flag follows the buffer, so a read with more held keeps it up
  assign rx_data_full_flag = buf_out_valid;
  assign rx_read_data = buf_out_data[RX_DATA_WIDTH-1:0];
  assign char_taken = buf_out_valid & rx_read_ready;

  ////////////////////////////////////////////////////////////////////
  // Error flags: the set wins over a clear in the same cycle

  logic pe_q;
  logic fe_q;
  logic ovr_q;
  logic any_error;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pe_q <= FLAG_RESET;
    end else if (char_taken && buf_out_data[ENTRY_PE_BIT]) begin
      pe_q <= 1'b1;
    end else if (error_clear) begin
      pe_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      fe_q <= FLAG_RESET;
    end else if (char_taken && buf_out_data[ENTRY_FE_BIT]) begin
      fe_q <= 1'b1;
    end else if (error_clear) begin
      fe_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ovr_q <= FLAG_RESET;
    end else if (shift_char_valid && fifo_full) begin
      ovr_q <= 1'b1;
    end else if (error_clear) begin
      ovr_q <= 1'b0;
    end
  end

  assign parity_error_flag = pe_q;
  assign framing_error_flag = fe_q;
  assign overrun_flag = ovr_q;
  assign any_error = pe_q | fe_q | ovr_q;

  ////////////////////////////////////////////////////////////////////
  // Inhibit bit and requests

  logic inhibit_q;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      inhibit_q <= INHIBIT_RESET;
    end else if (inhibit_write) begin
      inhibit_q <= inhibit_wdata;
    end
  end

  assign dfull_irq_inhibit = inhibit_q;

  // Tie carrier_detect_input low on channels without that input
  assign rx_interrupt = rx_interrupt_enable &
                        ((rx_data_full_flag & ~inhibit_q) |
                         any_error | carrier_detect_input);
  assign rx_dma_request = rx_dma_enable & rx_data_full_flag & ~any_error;

  ////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  logic [17:0] gap_q;
  logic period_ok_q;
  logic [20:0] cfg_prev_q;
  logic [20:0] cfg_now;
  logic [17:0] want_period;

  assign cfg_now = {generator_mode_select, prescale_select, speed_select_field, time_constant};
  assign want_period = generator_mode_select ?
                       (({1'b0, time_constant} + TC_HALF_OFFSET) << 1) :
                       {7'h00, classic_limit(prescale_select, speed_select_field)} +
                       18'h00001;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      gap_q <= 18'h00000;
      period_ok_q <= 1'b0;
      cfg_prev_q <= '0;
    end else begin
      cfg_prev_q <= cfg_now;
      gap_q <= src_tick ? 18'h00000 : gap_q + 18'h00001;
      if (cfg_now != cfg_prev_q || ext_mode) begin
        period_ok_q <= 1'b0;
      end else if (src_tick) begin
        period_ok_q <= 1'b1;
      end
    end
  end

  property p_src_period;
    src_tick && period_ok_q && !ext_mode && cfg_now == cfg_prev_q
      |-> gap_q == want_period - 18'h00001;
  endproperty
  a_src_period: assert property (p_src_period) else $error("source tick period wrong");

  property p_ext_edge;
    ext_mode && ext_serial_clock_pin && !$past(ext_serial_clock_pin) |-> src_tick;
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("external edge not used");

  property p_unity;
    clock_mode == ASB_MODE_X1 && $stable(clock_mode) && src_tick |=> rx_bit_tick && tx_bit_tick;
  endproperty
  a_unity: assert property (p_unity) else $error("unity mode missed a tick");

  property p_mode_src;
    rx_bit_tick |-> $past(src_tick) && $past(clock_mode) != ASB_MODE_RSVD;
  endproperty
  a_mode_src: assert property (p_mode_src) else $error("bit tick without source");

  property p_push_flag;
    shift_char_valid && !fifo_full |-> ##[1:3] rx_data_full_flag;
  endproperty
  a_push_flag: assert property (p_push_flag) else $error("data-full not set");

  property p_keep_full;
    char_taken && fifo_cnt_q != 3'h0 |=> rx_data_full_flag;
  endproperty
  a_keep_full: assert property (p_keep_full) else $error("data-full dropped");

  property p_dma_block;
    any_error |-> !rx_dma_request;
  endproperty
  a_dma_block: assert property (p_dma_block) else $error("DMA during error");

  property p_inhibit;
    inhibit_q && !any_error && !carrier_detect_input |-> !rx_interrupt;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibited interrupt raised");

  property p_err_irq;
    rx_interrupt_enable && (any_error || carrier_detect_input) |-> rx_interrupt;
  endproperty
  a_err_irq: assert property (p_err_irq) else $error("error interrupt missing");

  property p_reset_inhibit;
    @(posedge clk_sys) disable iff (1'b0) !reset_n |=> !dfull_irq_inhibit;
  endproperty
  a_reset_inhibit: assert property (p_reset_inhibit) else $error("inhibit not cleared");

  property p_overrun;
    shift_char_valid && fifo_full |=> overrun_flag && ($stable(fifo_cnt_q) || $past(fifo_pop));
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  c_gen_tick: cover property (generator_mode_select && !ext_mode && rx_bit_tick);
  c_overrun: cover property (shift_char_valid && fifo_full);
  c_dma: cover property (rx_dma_request && rx_read_ready);
  c_inhibit_err: cover property (inhibit_q && any_error && rx_interrupt);

endmodule

// file: hdl/asb_pkg.sv
package asb_pkg;

  // Baud generator arithmetic
  localparam int TC_WIDTH = 16;
  localparam logic [16:0] TC_HALF_OFFSET = 17'h00002;
  localparam logic [10:0] CLASSIC_BASE_DIV = 11'h00A;
  localparam logic [10:0] PRESCALE_EXTRA_DIV = 11'h014;
  localparam int CLASSIC_CNT_WIDTH = 11;
  localparam logic [2:0] SPEED_EXT_CLOCK = 3'h7;

  // Clock-mode divider
  localparam int MODE_CNT_WIDTH = 6;
  localparam logic [5:0] MODE_LIMIT_X16 = 6'h0F;
  localparam logic [5:0] MODE_LIMIT_X64 = 6'h3F;
  localparam logic [5:0] MODE_LIMIT_X1 = 6'h00;

  // Clock-mode code is {unity_clock_select, oversample_select}
  typedef enum logic [1:0] {
    ASB_MODE_X16 = 2'b00,
    ASB_MODE_X64 = 2'b01,
    ASB_MODE_X1 = 2'b10,
    ASB_MODE_RSVD = 2'b11
  } asb_clock_mode_type;

  // Receive path
  localparam int RX_DATA_WIDTH = 8;
  localparam int RX_ENTRY_WIDTH = RX_DATA_WIDTH + 2;
  localparam int RX_FIFO_DEPTH = 4;
  localparam int RX_PTR_WIDTH = 2;
  localparam logic [2:0] RX_FIFO_FULL_CNT = 3'h4;
  localparam int ENTRY_PE_BIT = 9;
  localparam int ENTRY_FE_BIT = 8;

  // Reset values
  localparam logic INHIBIT_RESET = 1'b0;
  localparam logic FLAG_RESET = 1'b0;

endpackage

// file: hdl/asb_pair_buffer.sv
`timescale 1ns/1ps
// Two-entry buffer: full throughput, and a stall on the drain side
// loses nothing because the fill side sees in_ready drop.
module asb_pair_buffer
  import asb_pkg::*;
#(
  parameter int WIDTH = 10
) (
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic in_valid, // Word offered
  output logic in_ready, // Room for a word
  input wire logic [WIDTH-1:0] in_data, // Word in
  output logic out_valid, // Word held
  input wire logic out_ready, // Drain takes head word
  output logic [WIDTH-1:0] out_data // Head word
);

  logic [WIDTH-1:0] slot_q [2];
  logic wr_sel_q;
  logic rd_sel_q;
  logic [1:0] count_q;
  logic push;
  logic pop;

  assign in_ready = (count_q != 2'h2);
  assign out_valid = (count_q != 2'h0);
  assign out_data = slot_q[rd_sel_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      slot_q[wr_sel_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wr_sel_q <= 1'b0;
      rd_sel_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        wr_sel_q <= ~wr_sel_q;
      end
      if (pop) begin
        rd_sel_q <= ~rd_sel_q;
      end
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

// file: testbench/asb_far_end.sv
`timescale 1ns/1ps
// Remote side: sends completed characters and a free-running serial clock.
module asb_far_end
  import asb_pkg::*;
#(
  parameter int EXT_HALF = 4
) (
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic char_req, // Bench asks for one character
  input wire logic [7:0] char_data, // Character to send
  input wire logic char_pe, // Send with bad parity
  input wire logic char_fe, // Send with bad stop bit
  output logic ext_serial_clock_pin, // Serial clock to the channel
  output logic shift_char_valid, // Character complete
  output logic [7:0] shift_char_data, // Completed character
  output logic shift_parity_err, // Parity bad
  output logic shift_framing_err // Stop bit bad
);
  int half_cnt;

  initial begin
    half_cnt = 0;
    ext_serial_clock_pin = 1'b0;
    shift_char_valid = 1'b0;
    shift_char_data = 8'h00;
    shift_parity_err = 1'b0;
    shift_framing_err = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Equal high and low halves
  always @(posedge clk_sys) begin
    if (half_cnt == EXT_HALF - 1) begin
      half_cnt <= 0;
      ext_serial_clock_pin <= ~ext_serial_clock_pin;
    end else begin
      half_cnt <= half_cnt + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stale data is inverted so nothing can rely on it
  always @(posedge clk_sys) begin
    shift_char_valid <= char_req;
    if (char_req) begin
      shift_char_data <= char_data;
      shift_parity_err <= char_pe;
      shift_framing_err <= char_fe;
    end else begin
      shift_char_data <= ~shift_char_data;
      shift_parity_err <= ~shift_parity_err;
      shift_framing_err <= ~shift_framing_err;
    end
  end
endmodule

// file: testbench/test_async_serial_baud_and_rx_status.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module test_async_serial_baud_and_rx_status
  import asb_pkg::*;
;
  localparam int EXT_HALF = 4;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] speed_select_field = 3'h0;
  logic prescale_select = 1'b0, oversample_select = 1'b0, unity_clock_select = 1'b1;
  logic generator_mode_select = 1'b0;
  logic [15:0] time_constant = 16'h0000;
  logic rx_read_ready = 1'b0, error_clear = 1'b0, inhibit_write = 1'b0, inhibit_wdata = 1'b0;
  logic rx_interrupt_enable = 1'b1, rx_dma_enable = 1'b1, carrier_detect_input = 1'b0;
  logic char_req = 1'b0, char_pe = 1'b0, char_fe = 1'b0;
  logic [7:0] char_data = 8'h00;
  logic ext_serial_clock_pin, rx_bit_tick, tx_bit_tick, shift_char_valid;
  logic shift_parity_err, shift_framing_err, rx_data_full_flag, parity_error_flag;
  logic framing_error_flag, overrun_flag, dfull_irq_inhibit, rx_interrupt, rx_dma_request;
  logic [7:0] shift_char_data, rx_read_data;
  int fail_count = 0;
  int checks_done = 0;
  int seed = 55;
  logic [9:0] exp_q[$];
  logic pe_m = 1'b0, fe_m = 1'b0, ovr_m = 1'b0;

  always #4 clk_sys = ~clk_sys;

  asb_far_end #(.EXT_HALF(EXT_HALF)) u_far (.clk_sys(clk_sys), .reset_n(reset_n),
    .char_req(char_req), .char_data(char_data), .char_pe(char_pe), .char_fe(char_fe),
    .ext_serial_clock_pin(ext_serial_clock_pin), .shift_char_valid(shift_char_valid),
    .shift_char_data(shift_char_data), .shift_parity_err(shift_parity_err),
    .shift_framing_err(shift_framing_err));

  asb_serial_core u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .speed_select_field(speed_select_field), .prescale_select(prescale_select),
    .oversample_select(oversample_select), .unity_clock_select(unity_clock_select),
    .generator_mode_select(generator_mode_select), .time_constant(time_constant),
    .ext_serial_clock_pin(ext_serial_clock_pin), .rx_bit_tick(rx_bit_tick),
    .tx_bit_tick(tx_bit_tick), .shift_char_valid(shift_char_valid),
    .shift_char_data(shift_char_data), .shift_parity_err(shift_parity_err),
    .shift_framing_err(shift_framing_err), .rx_read_ready(rx_read_ready),
    .rx_read_data(rx_read_data), .rx_data_full_flag(rx_data_full_flag),
    .parity_error_flag(parity_error_flag), .framing_error_flag(framing_error_flag),
    .overrun_flag(overrun_flag), .error_clear(error_clear), .inhibit_write(inhibit_write),
    .inhibit_wdata(inhibit_wdata), .dfull_irq_inhibit(dfull_irq_inhibit),
    .rx_interrupt_enable(rx_interrupt_enable), .rx_dma_enable(rx_dma_enable),
    .carrier_detect_input(carrier_detect_input), .rx_interrupt(rx_interrupt),
    .rx_dma_request(rx_dma_request));

  ////////////////////////////////////////////////////////////////////////
  function automatic int bdiv(logic g, logic u, logic o, logic p, logic [2:0] s, int tc);
    int f;
    f = u ? 1 : (o ? 64 : 16);
    if (s == 3'h7) return 2 * EXT_HALF * f;
    if (g) return 2 * (tc + 2) * f;
    return ((10 + 20 * p) << s) * f;
  endfunction

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // First periods after a change may be irregular, so only the last one counts
  task automatic cfg(input logic g, u, o, p, input logic [2:0] s, input int tc);
    int n, per;
    logic tk;
    generator_mode_select <= g;
    unity_clock_select <= u;
    oversample_select <= o;
    prescale_select <= p;
    speed_select_field <= s;
    time_constant <= tc[15:0];
    for (int sel = 0; sel < 2; sel++) begin
      for (int k = 0; k < 4; k++) begin
        n = 0;
        do begin
          @(negedge clk_sys);
          n++;
          tk = sel ? tx_bit_tick : rx_bit_tick;
        end while (tk !== 1'b1 && n < 8000);
        per = n;
      end
      `CHK(per, bdiv(g, u, o, p, s, tc))
    end
    @(posedge clk_sys);
  endtask

  task automatic push(input logic [7:0] d, input logic pe, input logic fe);
    char_req <= 1'b1;
    char_data <= d;
    char_pe <= pe;
    char_fe <= fe;
    @(posedge clk_sys);
    if (exp_q.size() < 6) exp_q.push_back({pe, fe, d});
    else ovr_m = 1'b1;
  endtask

  task automatic rd();
    logic [9:0] e;
    int n;
    n = 0;
    rx_read_ready <= 1'b1;
    do begin
      @(negedge clk_sys);
      n++;
    end while (rx_data_full_flag !== 1'b1 && n < 50);
    e = exp_q.pop_front();
    `CHK(rx_read_data, e[7:0])
    pe_m |= e[9];
    fe_m |= e[8];
    @(posedge clk_sys);
    rx_read_ready <= 1'b0;
    @(negedge clk_sys);
    `CHK(parity_error_flag, pe_m)
    `CHK(framing_error_flag, fe_m)
    `CHK(rx_dma_request, exp_q.size() != 0 && !(pe_m || fe_m || ovr_m))
    if (exp_q.size() != 0) begin
      `CHK(rx_data_full_flag, 1'b1)
      `CHK(rx_interrupt, 1'b1)
    end
    @(posedge clk_sys);
  endtask

  task automatic clr();
    error_clear <= 1'b1;
    @(posedge clk_sys);
    error_clear <= 1'b0;
    {pe_m, fe_m, ovr_m} = 3'h0;
  endtask

  task automatic inh(input logic v);
    inhibit_write <= 1'b1;
    inhibit_wdata <= v;
    @(posedge clk_sys);
    inhibit_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (90000) @(posedge clk_sys);
    fail_count++;
    summarize();
  end

  initial begin
    int tc, n;
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(negedge clk_sys);
    `CHK(dfull_irq_inhibit, 1'b0)
    @(posedge clk_sys);
    for (int s = 0; s < 8; s++) cfg(1'b0, 1'b1, 1'b0, s[0], s[2:0], 0);
    repeat (2) begin
      tc = $random(seed) & 15;
      cfg(1'b1, 1'b1, 1'b0, 1'b0, 3'h0, tc);
    end
    cfg(1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 0);
    cfg(1'b0, 1'b0, 1'b0, 1'b0, 3'h0, 0);
    cfg(1'b0, 1'b0, 1'b1, 1'b0, 3'h0, 0);
    cfg(1'b0, 1'b0, 1'b0, 1'b0, 3'h7, 0);
    cfg(1'b1, 1'b1, 1'b0, 1'b0, 3'h7, 3);
    // Reserved clock mode must stay silent
    oversample_select <= 1'b1;
    repeat (5) @(posedge clk_sys);
    n = 0;
    repeat (400) begin
      @(negedge clk_sys);
      n += (rx_bit_tick !== 1'b0) + (tx_bit_tick !== 1'b0);
    end
    `CHK(n, 0)
    cfg(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 0);
    push(8'($random(seed)), 1'b0, 1'b0);
    char_req <= 1'b0;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK(rx_data_full_flag, 1'b1)
    `CHK(rx_interrupt, 1'b1)
    `CHK(rx_dma_request, 1'b1)
    @(posedge clk_sys);
    inh(1'b1);
    @(negedge clk_sys);
    `CHK(rx_interrupt, 1'b0)
    `CHK(rx_dma_request, 1'b1)
    @(posedge clk_sys);
    carrier_detect_input <= 1'b1;
    @(negedge clk_sys);
    `CHK(rx_interrupt, 1'b1)
    @(posedge clk_sys);
    carrier_detect_input <= 1'b0;
    rd();
    // Reader stalls while seven characters arrive back to back
    for (int k = 0; k < 7; k++) push(8'($random(seed)), k == 1, k == 2);
    char_req <= 1'b0;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK(overrun_flag, ovr_m)
    `CHK(rx_interrupt, 1'b1)
    `CHK(rx_dma_request, 1'b0)
    @(posedge clk_sys);
    clr();
    @(negedge clk_sys);
    `CHK(rx_dma_request, 1'b1)
    @(posedge clk_sys);
    inh(1'b0);
    while (exp_q.size() != 0) begin
      rd();
      if (pe_m || fe_m) clr();
    end
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK(rx_data_full_flag, 1'b0)
    summarize();
  end
endmodule
